// ---- rtl/uht_pkg.sv ----
// Purpose: Shared constants of the upper half timer control block.
// Assumes: 32-bit classic Wishbone, word aligned registers.
// Notes: Control layout, register offsets and prescale ratios.
`default_nettype none

package uht_pkg;

   // ***************************************************
   // Register offsets (byte addresses)
   // ***************************************************
   localparam logic [4:0] OFF_CTRL = 5'h00;     // Control register
   localparam logic [4:0] OFF_COUNT = 5'h04;    // Running count
   localparam logic [4:0] OFF_PERIOD = 5'h08;   // Period value
   localparam logic [4:0] OFF_STATUS = 5'h0C;   // Sticky events, read only
   localparam logic [4:0] OFF_INT_CLR = 5'h10;  // Write one to clear
   localparam logic [4:0] OFF_INT_EN = 5'h14;   // Interrupt enables

   // ***************************************************
   // Control field positions
   // ***************************************************
   localparam int RUN_BIT = 15;    // Run control
   localparam int IDLE_BIT = 13;   // Stop in idle select
   localparam int GATE_BIT = 6;    // Gated accumulation enable
   localparam int PSC_LSB = 4;     // Prescale select, two bits
   localparam int CS_BIT = 1;      // Clock source select

   // Writable bits of the control register
   localparam logic [15:0] CTRL_MASK = 16'hA072;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

   // ***************************************************
   // Event bits
   // ***************************************************
   localparam int EV_W = 2;        // Number of event bits
   localparam int EV_MATCH = 0;    // Period match
   localparam int EV_EXT = 1;      // External edge seen while counting

   // ***************************************************
   // Prescale ratios and internal clock
   // ***************************************************
   localparam logic [8:0] RATIO_0 = 9'h001;   // 1:1
   localparam logic [8:0] RATIO_1 = 9'h008;   // 1:8
   localparam logic [8:0] RATIO_2 = 9'h040;   // 1:64
   localparam logic [8:0] RATIO_3 = 9'h100;   // 1:256
   localparam int FOSC_DIV = 2;               // Internal clock is Fosc/2

endpackage : uht_pkg

`default_nettype wire

// ---- rtl/uht_prescaler.sv ----
// Purpose: Divides the source tick by 1, 8, 64 or 256.
// Assumes: src_tick is a one-cycle pulse on clk_i.
// Notes: tick is combinational from the divider state and src_tick.
`default_nettype none

module uht_prescaler
(
   input wire logic clk_i,
   input wire logic rst_i,
   uht_tick_if.psc tk
);

   // ***************************************************
   // Ratio decode
   // ***************************************************
   // Returns the division ratio less one
   function automatic logic [7:0] ratio_m1(input logic [1:0] sel);
      logic [8:0] r;
      r = uht_pkg::RATIO_0;
      case (sel)
         2'b01: r = uht_pkg::RATIO_1;
         2'b10: r = uht_pkg::RATIO_2;
         2'b11: r = uht_pkg::RATIO_3;
         default: r = uht_pkg::RATIO_0;
      endcase
      return 8'(r - 9'h001);
   endfunction : ratio_m1

   logic [7:0] cnt_r;       // Divider position
   logic [7:0] cnt_nxt;
   wire logic [7:0] top_w = ratio_m1(tk.psc_sel);
   wire logic last_w = (cnt_r >= top_w);

   // Pass a tick out when the divider reaches its last step
   assign tk.tick = tk.src_tick && last_w && !tk.clr;

   assign cnt_nxt = tk.clr ? 8'h00 :
                    !tk.src_tick ? cnt_r :
                    last_w ? 8'h00 : 8'(cnt_r + 8'h01);

   // Divider register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_r <= 8'h00;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_psc_passthru: assert property (
      tk.psc_sel == 2'b00 && tk.src_tick && !tk.clr |-> tk.tick)
      else $error("ratio 1:1 dropped a tick");
   a_psc_ratio_8: assert property (
      tk.tick && tk.psc_sel == 2'b01 |-> cnt_r == 8'h07)
      else $error("ratio 1:8 tick at wrong step");
   a_psc_ratio_256: assert property (
      tk.tick && tk.psc_sel == 2'b11 |-> cnt_r == 8'hFF)
      else $error("ratio 1:256 tick at wrong step");

endmodule : uht_prescaler

`default_nettype wire

// ---- rtl/uht_tick_if.sv ----
// Purpose: Carries the source tick and prescale control to the prescaler.
// Assumes: Single clock domain.
// Notes: ctl drives the source side, psc answers with a divided tick.
`default_nettype none

interface uht_tick_if;
   logic src_tick;          // Undivided count tick
   logic [1:0] psc_sel;     // Prescale select
   logic clr;               // Restart the divider
   logic tick;              // Divided tick

   modport ctl (output src_tick, output psc_sel, output clr, input tick);
   modport psc (input src_tick, input psc_sel, input clr, output tick);
endinterface : uht_tick_if

`default_nettype wire

// ---- rtl/uht_top.sv ----
// Purpose: Upper 16-bit timer of a pair, with its control register.
// Assumes: clk_i is the oscillator clock; idle and pair inputs come
//          from logic on clk_i; pins come from outside and are synced.
// Notes: Registers reached over classic Wishbone, one word each.
//
// Notes on behaviour
// - Run bit starts, clearing it stops counting.
// - Idle stop bit halts timer during idle.
// - Gate bit ignored when external clock selected.
// - Internal clock with gate counts only while gated.
// - Prescale 11 divides 256, 00 passes through.
// - Prescale 10 divides 64, 01 divides 8.
// - Clock source set counts external rising edges.
// - Clock source clear counts at half oscillator.
// - Wide pair mode makes this control inert.
// - Unimplemented control bits read back zero.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`default_nettype none

module uht_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic idle_i,
   input wire logic pair_wide_select_i,
   input wire logic external_count_pin_i,
   input wire logic gate_pin_i,
   output logic irq_o,
   output logic match_o
);

   // ***************************************************
   // Byte lane helper
   // ***************************************************
   // Merges write data into a 16-bit value under the byte enables
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [15:0] dat,
                                              input logic [1:0] sel);
      logic [15:0] res;
      res = old;
      if (sel[0])
      begin
         res[7:0] = dat[7:0];
      end
      if (sel[1])
      begin
         res[15:8] = dat[15:8];
      end
      return res;
   endfunction : lane_merge

   // ***************************************************
   // State
   // ***************************************************
   logic [15:0] ctrl_r;                // Control register
   logic [15:0] count_r;               // Timer count
   logic [15:0] period_r;              // Period value
   logic [uht_pkg::EV_W-1:0] status_r; // Sticky events
   logic [uht_pkg::EV_W-1:0] int_en_r; // Interrupt enables
   logic ack_r;                        // Bus answer
   logic [31:0] dat_r;                 // Read data
   logic irq_r;                        // Interrupt level
   logic match_r;                      // Period match pulse
   logic int_cnt_r;                    // Fosc divider
   logic ext_s1_r;                     // Pin sync, first stage
   logic ext_s2_r;                     // Pin sync, second stage
   logic ext_s3_r;                     // Previous synced pin
   logic gate_s1_r;                    // Gate sync, first stage
   logic gate_s2_r;                    // Gate sync, second stage

   uht_tick_if tk ();

   // ***************************************************
   // Bus decode
   // ***************************************************
   wire logic req_w = wb_cyc_i && wb_stb_i && !ack_r;
   // Writes land at the edge where the master samples ack high
   wire logic wr_w = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
   wire logic rd_w = req_w && !wb_we_i;
   wire logic hit_ctrl_w = (wb_adr_i == uht_pkg::OFF_CTRL);
   wire logic hit_count_w = (wb_adr_i == uht_pkg::OFF_COUNT);
   wire logic hit_period_w = (wb_adr_i == uht_pkg::OFF_PERIOD);
   wire logic hit_status_w = (wb_adr_i == uht_pkg::OFF_STATUS);
   wire logic hit_clr_w = (wb_adr_i == uht_pkg::OFF_INT_CLR);
   wire logic hit_en_w = (wb_adr_i == uht_pkg::OFF_INT_EN);
   wire logic ctrl_wr_w = wr_w && hit_ctrl_w;
   wire logic count_wr_w = wr_w && hit_count_w;
   wire logic period_wr_w = wr_w && hit_period_w;
   wire logic clr_wr_w = wr_w && hit_clr_w && wb_sel_i[0];
   wire logic en_wr_w = wr_w && hit_en_w && wb_sel_i[0];

   // ***************************************************
   // Control fields
   // ***************************************************
   wire logic run_control = ctrl_r[uht_pkg::RUN_BIT];
   wire logic idle_stop_select = ctrl_r[uht_pkg::IDLE_BIT];
   wire logic gated_accumulate_enable = ctrl_r[uht_pkg::GATE_BIT];
   wire logic [1:0] prescale_select = ctrl_r[uht_pkg::PSC_LSB +: 2];
   wire logic clock_source_select = ctrl_r[uht_pkg::CS_BIT];

   // Counting allowed: running, not halted by idle, not in wide mode
   wire logic count_active_w = run_control
                               && !(idle_i && idle_stop_select)
                               && !pair_wide_select_i;

   // ***************************************************
   // Tick sources
   // ***************************************************
   // Internal clock runs at half the oscillator
   wire logic int_tick_w = (int_cnt_r == 1'(uht_pkg::FOSC_DIV - 1));
   // Rising edge of the synced external pin
   wire logic ext_edge_w = ext_s2_r && !ext_s3_r;
   // Gate passes internal ticks only while active when gating is on
   wire logic gate_open_w = !gated_accumulate_enable || gate_s2_r;
   // External source ignores the gate bit
   wire logic src_tick_w = !count_active_w ? 1'b0 :
                           clock_source_select ? ext_edge_w :
                           (int_tick_w && gate_open_w);

   assign tk.src_tick = src_tick_w;
   assign tk.psc_sel = prescale_select;
   // Rewriting control restarts the divider
   assign tk.clr = ctrl_wr_w || !count_active_w;

   uht_prescaler u_psc
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tk(tk.psc)
   );

   // ***************************************************
   // Count and events
   // ***************************************************
   wire logic at_period_w = (count_r == period_r);
   wire logic match_w = tk.tick && at_period_w && !count_wr_w;
   wire logic [15:0] count_nxt = count_wr_w ?
                      lane_merge(count_r, wb_dat_i[15:0], wb_sel_i[1:0]) :
                      !tk.tick ? count_r :
                      at_period_w ? 16'h0000 :
                      16'(count_r + 16'h0001);
   wire logic [uht_pkg::EV_W-1:0] ev_set_w = {ext_edge_w && count_active_w,
                                              match_w};
   wire logic [uht_pkg::EV_W-1:0] ev_clr_w =
        clr_wr_w ? wb_dat_i[uht_pkg::EV_W-1:0] : '0;
   // Hardware set wins over a software clear in the same cycle
   wire logic [uht_pkg::EV_W-1:0] status_nxt = (status_r & ~ev_clr_w) |
                                               ev_set_w;
   wire logic [15:0] ctrl_nxt = lane_merge(ctrl_r, wb_dat_i[15:0],
                                           wb_sel_i[1:0]) &
                                uht_pkg::CTRL_MASK;

   // ***************************************************
   // Read mux
   // ***************************************************
   wire logic [31:0] rd_dat_w =
        hit_ctrl_w ? {16'h0000, ctrl_r & uht_pkg::CTRL_MASK} :
        hit_count_w ? {16'h0000, count_r} :
        hit_period_w ? {16'h0000, period_r} :
        hit_status_w ? {{(32 - uht_pkg::EV_W){1'b0}}, status_r} :
        hit_en_w ? {{(32 - uht_pkg::EV_W){1'b0}}, int_en_r} :
        32'h0000_0000;

   // Synchronisers for the pins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
         gate_s1_r <= 1'b0;
         gate_s2_r <= 1'b0;
      end
      else
      begin
         ext_s1_r <= external_count_pin_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         gate_s1_r <= gate_pin_i;
         gate_s2_r <= gate_s1_r;
      end
   end

   // Internal clock divider
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         int_cnt_r <= 1'b0;
      end
      else
      begin
         int_cnt_r <= int_tick_w ? 1'b0 : 1'(int_cnt_r + 1'b1);
      end
   end

   // Software registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= uht_pkg::CTRL_RESET;
         period_r <= uht_pkg::PERIOD_RESET;
         int_en_r <= '0;
      end
      else
      begin
         if (ctrl_wr_w)
         begin
            ctrl_r <= ctrl_nxt;
         end
         if (period_wr_w)
         begin
            period_r <= lane_merge(period_r, wb_dat_i[15:0], wb_sel_i[1:0]);
         end
         if (en_wr_w)
         begin
            int_en_r <= wb_dat_i[uht_pkg::EV_W-1:0];
         end
      end
   end

   // Count, events and interrupt
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_r <= uht_pkg::COUNT_RESET;
         status_r <= '0;
         match_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         status_r <= status_nxt;
         match_r <= match_w;
         irq_r <= |(status_nxt & int_en_r);
      end
   end

   // Bus answer, one cycle after the request, unmapped reads zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= req_w;
         dat_r <= rd_w ? rd_dat_w : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign irq_o = irq_r;
   assign match_o = match_r;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_wrap;
      tk.tick && at_period_w && !count_wr_w;
   endsequence

   sequence s_cleared_flag;
      ##1 (count_r == 16'h0000) && status_r[uht_pkg::EV_MATCH] && match_o;
   endsequence

   a_run_stops_count: assert property (
      !count_active_w && !count_wr_w |=> count_r == $past(count_r))
      else $error("count moved while stopped");
   a_wide_mode_inert: assert property (
      pair_wide_select_i |-> !src_tick_w && !tk.tick)
      else $error("tick seen in wide pair mode");
   a_idle_halt: assert property (
      idle_i && idle_stop_select |-> !src_tick_w)
      else $error("tick during idle with stop set");
   a_idle_runs: assert property (
      idle_i && !idle_stop_select && run_control && !pair_wide_select_i
      && !clock_source_select && !gated_accumulate_enable
      |-> ##[0:1] src_tick_w)
      else $error("idle without stop halted the timer");
   a_gate_blocks: assert property (
      !clock_source_select && gated_accumulate_enable && !gate_s2_r
      |-> !src_tick_w)
      else $error("tick while gate closed");
   a_ext_ungated: assert property (
      clock_source_select && count_active_w && ext_edge_w |-> src_tick_w)
      else $error("external edge not counted");
   a_int_half_rate: assert property (
      src_tick_w && !clock_source_select |=> !src_tick_w)
      else $error("internal tick faster than half rate");
   a_reserved_zero: assert property (
      $past(rd_w && hit_ctrl_w)
      |-> (wb_dat_o & ~{16'h0000, uht_pkg::CTRL_MASK}) == 32'h0000_0000)
      else $error("unimplemented control bit read as one");
   a_period_wrap: assert property (
      s_wrap |-> s_cleared_flag)
      else $error("count did not wrap at period");
   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for two cycles");

endmodule : uht_top

`default_nettype wire

// ---- verif/uht_pin_model.sv ----
// Purpose: Far side pins: external count pin and gate pin.
// Assumes: One clock; the bench loads bursts of rising edges.
// Notes: Count pin idles low between bursts, one edge per 8 clocks.
`default_nettype none

module uht_pin_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [7:0] edges_i,
   input wire logic gate_i,
   output logic pin_o,
   output logic gate_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] left_r;  // Edges still to make
   logic [2:0] phase_r; // Position inside one pin period

   // ***************************************************
   // Edge burst generator
   // ***************************************************
   // Pin high four clocks, low four clocks, per edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         left_r <= 8'h00;
         phase_r <= 3'h0;
      end
      else if (load_i)
      begin
         left_r <= edges_i;
         phase_r <= 3'h0;
      end
      else if (left_r != 8'h00)
      begin
         phase_r <= phase_r + 3'h1;
         if (phase_r == 3'h7)
            left_r <= left_r - 8'h01;
      end
   end

   assign pin_o = (left_r != 8'h00) && (phase_r < 3'h4); // One rise
   assign busy_o = (left_r != 8'h00); // Burst in progress
   assign gate_o = gate_i; // Gate level, active high
endmodule : uht_pin_model

`default_nettype wire

// ---- verif/upper_half_timer_control_tb.sv ----
// Purpose: Self-checking bench of the upper half timer control block.
// Assumes: Classic Wishbone, one-cycle ack, 125 MHz clock.
// Notes: Each scenario is its own task; match gaps measure tick rates.
`default_nettype none

module upper_half_timer_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [4:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic idle_i, pair_i, pin, gate, irq_o, match_o;
   logic load, gate_cmd, busy;
   logic [7:0] edges;
   int n_mismatch = 0;
   int comparisons = 0;

   uht_top uht_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .idle_i(idle_i), .pair_wide_select_i(pair_i),
      .external_count_pin_i(pin), .gate_pin_i(gate), .irq_o(irq_o),
      .match_o(match_o));

   uht_pin_model uht_pin_model_i (.clk_i(clk_i), .rst_i(rst_i),
      .load_i(load), .edges_i(edges), .gate_i(gate_cmd), .pin_o(pin),
      .gate_o(gate), .busy_o(busy));

   // ***************************************************
   // Clock and closing report
   // ***************************************************
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task hang(input string m);
      n_mismatch++;
      $display("[FAIL] %0t timeout %s", $time, m);
      summarize();
   endtask : hang

   // ***************************************************
   // Bus cycles
   // ***************************************************
   // Single classic cycle, held until ack is sampled
   task wb(input logic w, input logic [4:0] a, input logic [15:0] d,
           output logic [31:0] q);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'b0011;
      wb_dat_i <= {16'h0000, d};
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1)
            break;
      end
      q = wb_dat_o;
      if (i == 20)
         hang("bus ack");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   task wr(input logic [4:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task rdc(input logic [4:0] a, input logic [31:0] exp, input string m);
      logic [31:0] q;
      wb(1'b0, a, 16'h0000, q);
      chk(q, exp, m);
   endtask : rdc

   // Count changes, or not, over a 40-clock window
   task moving(input logic exp);
      logic [31:0] a, b;
      wb(1'b0, uht_pkg::OFF_COUNT, 16'h0000, a);
      repeat (40) @(posedge clk_i);
      wb(1'b0, uht_pkg::OFF_COUNT, 16'h0000, b);
      chk({31'h0, a !== b}, {31'h0, exp}, "count motion");
   endtask : moving

   // Clocks between two successive match pulses
   task gap(input int exp);
      int n;
      for (n = 0; n < 3000; n++)
      begin
         @(posedge clk_i);
         if (match_o === 1'b1)
            break;
      end
      if (n == 3000)
         hang("first match");
      for (n = 1; n <= 3000; n++)
      begin
         @(posedge clk_i);
         if (match_o === 1'b1)
            break;
      end
      if (n > 3000)
         hang("match");
      chk(n, exp, "match gap");
   endtask : gap

   // ***************************************************
   // Scenarios
   // ***************************************************
   task t_reset;
      rdc(uht_pkg::OFF_CTRL, 32'h0000_0000, "ctrl reset");
      rdc(uht_pkg::OFF_COUNT, 32'h0000_0000, "count reset");
      rdc(uht_pkg::OFF_PERIOD, 32'h0000_FFFF, "period reset");
      rdc(uht_pkg::OFF_STATUS, 32'h0000_0000, "status reset");
      rdc(uht_pkg::OFF_INT_EN, 32'h0000_0000, "enable reset");
      rdc(5'h18, 32'h0000_0000, "unmapped read");
      chk({31'h0, irq_o}, 32'h0000_0000, "irq reset");
      wr(uht_pkg::OFF_CTRL, 16'hFFFF);
      rdc(uht_pkg::OFF_CTRL, 32'h0000_A072, "ctrl mask");
      wr(uht_pkg::OFF_CTRL, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task t_run;
      wr(uht_pkg::OFF_PERIOD, 16'h0002);
      wr(uht_pkg::OFF_COUNT, 16'h0000);
      wr(uht_pkg::OFF_INT_EN, 16'h0001);
      wr(uht_pkg::OFF_CTRL, 16'h8000);
      gap(6);
      rdc(uht_pkg::OFF_STATUS, 32'h0000_0001, "match flag");
      chk({31'h0, irq_o}, 32'h0000_0001, "irq raised");
      wr(uht_pkg::OFF_INT_EN, 16'h0000);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0000_0000, "irq masked");
      wr(uht_pkg::OFF_CTRL, 16'h0000);
      moving(1'b0);
      wr(uht_pkg::OFF_INT_CLR, 16'h0003);
      rdc(uht_pkg::OFF_STATUS, 32'h0000_0000, "status cleared");
      $display("test run done");
   endtask : t_run

   task t_psc;
      int ratio [4] = '{1, 8, 64, 256};
      for (int c = 0; c < 4; c++)
      begin
         wr(uht_pkg::OFF_PERIOD, 16'h0001);
         wr(uht_pkg::OFF_COUNT, 16'h0000);
         wr(uht_pkg::OFF_CTRL, 16'h8000 | (16'(c) << 4));
         gap(4 * ratio[c]);
      end
      $display("test prescale done");
   endtask : t_psc

   task t_modes;
      wr(uht_pkg::OFF_PERIOD, 16'hFFFF);
      wr(uht_pkg::OFF_CTRL, 16'hA000);
      moving(1'b1);
      idle_i <= 1'b1;
      moving(1'b0);
      wr(uht_pkg::OFF_CTRL, 16'h8000);
      moving(1'b1);
      idle_i <= 1'b0;
      pair_i <= 1'b1;
      moving(1'b0);
      pair_i <= 1'b0;
      wr(uht_pkg::OFF_CTRL, 16'h8040);
      moving(1'b0);
      gate_cmd <= 1'b1;
      moving(1'b1);
      gate_cmd <= 1'b0;
      $display("test modes done");
   endtask : t_modes

   task t_ext;
      int i;
      wr(uht_pkg::OFF_INT_CLR, 16'h0003);
      wr(uht_pkg::OFF_CTRL, 16'h8042);
      wr(uht_pkg::OFF_COUNT, 16'h0000);
      @(posedge clk_i);
      load <= 1'b1;
      edges <= 8'h05;
      @(posedge clk_i);
      load <= 1'b0;
      for (i = 0; i < 200; i++)
      begin
         @(posedge clk_i);
         if (busy === 1'b0)
            break;
      end
      if (i == 200)
         hang("pin burst");
      repeat (8) @(posedge clk_i);
      rdc(uht_pkg::OFF_COUNT, 32'h0000_0005, "edge count");
      rdc(uht_pkg::OFF_STATUS, 32'h0000_0002, "edge flag");
      wr(uht_pkg::OFF_CTRL, 16'h0000);
      $display("test external done");
   endtask : t_ext

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial
   begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 5'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      idle_i = 1'b0;
      pair_i = 1'b0;
      load = 1'b0;
      edges = 8'h00;
      gate_cmd = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_run();
      t_psc();
      t_modes();
      t_ext();
      summarize();
   end
endmodule : upper_half_timer_control_tb

`default_nettype wire
